// file: ild_map.vh
// ild_map.vh: offsets, field positions, widths and reset values of the
// input level detector alternate map.
// assumes: included by bare name from the detector design files.
`ifndef ILD_MAP_VH
`define ILD_MAP_VH

// ----------------------------------------------------------------
// alternate-map locations (channel address pointer values)
// ----------------------------------------------------------------
`define ILD_OFS_A_LOW_LIMIT 8'h00
`define ILD_OFS_A_HIGH_LIMIT 8'h01
`define ILD_OFS_A_HOLD_COUNT 8'h02
`define ILD_OFS_A_DETECT_CONFIG 8'h03
`define ILD_OFS_B_LOW_LIMIT 8'h04
`define ILD_OFS_B_HIGH_LIMIT 8'h05
`define ILD_OFS_B_HOLD_COUNT 8'h06
`define ILD_OFS_B_DETECT_CONFIG 8'h07

// ----------------------------------------------------------------
// location decode fields of the pointer
// ----------------------------------------------------------------
`define ILD_PTR_PORT_BIT 2
`define ILD_PTR_FIELD_MSB 1
`define ILD_PTR_FIELD_LSB 0
`define ILD_FIELD_LOW 2'h0
`define ILD_FIELD_HIGH 2'h1
`define ILD_FIELD_HOLD 2'h2
`define ILD_FIELD_CONFIG 2'h3

// ----------------------------------------------------------------
// widths and field positions
// ----------------------------------------------------------------
`define ILD_SAMPLE_W 14
`define ILD_MANT_MSB 13
`define ILD_MANT_LSB 4
`define ILD_LIMIT_W 10
`define ILD_HOLD_W 20
`define ILD_CONFIG_W 5
`define ILD_DATA_W 20
`define ILD_CFG_POLARITY_BIT 4
`define ILD_CFG_INTERLEAVE_BIT 3
`define ILD_CFG_HOLDOFF_MSB 2
`define ILD_CFG_HOLDOFF_LSB 0
`define ILD_HOLDOFF_TAPS 8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ILD_RST_LIMIT 10'h000
`define ILD_RST_HOLD 20'h00000
`define ILD_RST_CONFIG 5'h00

`endif

// file: ild_sync.v
// ild_sync.v: two-flop synchroniser for a bundle of pin inputs.
// assumes: bits are independent levels; multi-bit sample words may tear
// for one cycle, which the detector tolerates as a single odd sample.
`timescale 1ns/1ps
`default_nettype none

module ild_sync #(
	parameter W = 30
) (
	// clock and control
	input wire i_core_clk,
	input wire i_rst_n,
	input wire i_ce,
	// pins
	input wire [W-1:0] i_async,
	// synchronised
	output reg [W-1:0] o_sync
);

reg [W-1:0] meta;

always @(posedge i_core_clk)
begin
	if (!i_rst_n)
	begin
		meta <= {W{1'b0}};
		o_sync <= {W{1'b0}};
	end
	else if (i_ce)
	begin
		meta <= i_async;
		o_sync <= meta;
	end
end

endmodule
`default_nettype wire

// file: ild_holdoff.v
// ild_holdoff.v: programmable delay of the indicator level, 0 to 7 cycles.
// assumes: select comes from a static configuration field.
`timescale 1ns/1ps
`default_nettype none
`include "ild_map.vh"

module ild_holdoff (
	// clock and control
	input wire i_core_clk,
	input wire i_rst_n,
	input wire i_ce,
	// level in and delay select
	input wire i_level,
	input wire [2:0] i_sel,
	// delayed level
	output wire o_level
);

wire [`ILD_HOLDOFF_TAPS-1:0] tap;
reg [`ILD_HOLDOFF_TAPS-1:1] line;

assign tap[0] = i_level;

genvar k;
generate
	for (k = 1; k < `ILD_HOLDOFF_TAPS; k = k + 1)
	begin : g_tap
		always @(posedge i_core_clk)
		begin
			if (!i_rst_n)
				line[k] <= 1'b0;
			else if (i_ce)
				line[k] <= tap[k-1];
		end
		assign tap[k] = line[k];
	end
endgenerate

// a changed select takes effect at once; a glitch may show while it changes
assign o_level = tap[i_sel];

endmodule
`default_nettype wire

// file: ild_top.v
// ild_top.v: input level detector for two sample ports, with its eight
// alternate-map locations and the four level-indicator outputs.
// assumes: one sample clock; access strobes come from logic on that clock;
// sample buses and input enables are pins and are synchronised here.
//
// Operation
// - lower limit met when top ten mantissa bits are at or below it
// - upper limit met when top ten bits reach it; indicator then active
// - lower met after upper excursion: load dwell counter, count while low
// - input above lower limit during dwell reloads counter and waits again
// - indicator released only after dwell time spent at or below lower limit
// - dwell of zero disables detection; software programs at least one
// - config bit 4 clear: active high; set: active low
// - config bit 3 clear: first output active, second its complement
// - config bit 3 set: input enable low selects first, high selects second
// - config bits 2-0 set hold-off delay of the indicator signal
// - locations 4-7 serve port B as 0-3 serve port A
// - locations reachable only with map select set; pointer picks location
`timescale 1ns/1ps
`default_nettype none
`include "ild_map.vh"

module ild_top (
	// clock, reset, enable
	input wire i_core_clk,
	input wire i_rst_n,
	input wire i_ce,
	// sample pins
	input wire [`ILD_SAMPLE_W-1:0] i_port_a_sample_bus,
	input wire [`ILD_SAMPLE_W-1:0] i_port_b_sample_bus,
	input wire i_port_a_input_enable,
	input wire i_port_b_input_enable,
	// internal access from the control port
	input wire i_map_select,
	input wire [7:0] i_channel_address_pointer,
	input wire i_wr_strobe,
	input wire i_rd_strobe,
	input wire [`ILD_DATA_W-1:0] i_wr_data,
	output wire [`ILD_DATA_W-1:0] o_rd_data,
	output wire o_rd_valid,
	// level indicators
	output wire o_port_a_indicator_first,
	output wire o_port_a_indicator_second,
	output wire o_port_b_indicator_first,
	output wire o_port_b_indicator_second
);

// ----------------------------------------------------------------
// detector states, one-hot
// ----------------------------------------------------------------
localparam [2:0] ST_IDLE = 3'b001;
localparam [2:0] ST_ARMED = 3'b010;
localparam [2:0] ST_DWELL = 3'b100;

// ----------------------------------------------------------------
// location decode
// ----------------------------------------------------------------
// only pointer values 0 to 7 exist in the alternate map
function ild_loc_ok;
	input [7:0] ptr;
	begin
		ild_loc_ok = (ptr[7:3] == 5'h00);
	end
endfunction

// ----------------------------------------------------------------
// pin synchronisation
// ----------------------------------------------------------------
localparam SYNC_W = 2 * `ILD_SAMPLE_W + 2;

wire [SYNC_W-1:0] pins_sync;

ild_sync #(
	.W(SYNC_W)
) u_sync (
	.i_core_clk(i_core_clk),
	.i_rst_n(i_rst_n),
	.i_ce(i_ce),
	.i_async({i_port_b_input_enable, i_port_a_input_enable,
		i_port_b_sample_bus, i_port_a_sample_bus}),
	.o_sync(pins_sync)
);

wire [`ILD_SAMPLE_W-1:0] sample_s [0:1];
wire [1:0] ien_s;

assign sample_s[0] = pins_sync[`ILD_SAMPLE_W-1:0];
assign sample_s[1] = pins_sync[2*`ILD_SAMPLE_W-1:`ILD_SAMPLE_W];
assign ien_s = pins_sync[SYNC_W-1:2*`ILD_SAMPLE_W];

// ----------------------------------------------------------------
// location storage, index 0 = port A, 1 = port B
// ----------------------------------------------------------------
reg [`ILD_LIMIT_W-1:0] low_limit [0:1];
reg [`ILD_LIMIT_W-1:0] high_limit [0:1];
reg [`ILD_HOLD_W-1:0] hold_count [0:1];
reg [`ILD_CONFIG_W-1:0] detect_config [0:1];

wire acc_hit;
wire acc_port;
wire [1:0] acc_field;

assign acc_hit = i_map_select & ild_loc_ok(i_channel_address_pointer);
assign acc_port = i_channel_address_pointer[`ILD_PTR_PORT_BIT];
assign acc_field = i_channel_address_pointer[`ILD_PTR_FIELD_MSB:`ILD_PTR_FIELD_LSB];

integer n;

always @(posedge i_core_clk)
begin
	if (!i_rst_n)
	begin
		for (n = 0; n < 2; n = n + 1)
		begin
			low_limit[n] <= `ILD_RST_LIMIT;
			high_limit[n] <= `ILD_RST_LIMIT;
			hold_count[n] <= `ILD_RST_HOLD;
			detect_config[n] <= `ILD_RST_CONFIG;
		end
	end
	else if (i_ce && i_wr_strobe && acc_hit)
	begin
		if (acc_field == `ILD_FIELD_LOW)
			low_limit[acc_port] <= i_wr_data[`ILD_LIMIT_W-1:0];
		else if (acc_field == `ILD_FIELD_HIGH)
			high_limit[acc_port] <= i_wr_data[`ILD_LIMIT_W-1:0];
		else if (acc_field == `ILD_FIELD_HOLD)
			hold_count[acc_port] <= i_wr_data[`ILD_HOLD_W-1:0];
		else
			detect_config[acc_port] <= i_wr_data[`ILD_CONFIG_W-1:0];
	end
end

// ----------------------------------------------------------------
// read path
// ----------------------------------------------------------------
reg [`ILD_DATA_W-1:0] rd_data;
reg rd_valid;
reg [`ILD_DATA_W-1:0] next_rd_data;

always @*
begin
	next_rd_data = {`ILD_DATA_W{1'b0}};
	if (!acc_hit)
		next_rd_data = {`ILD_DATA_W{1'b0}};
	else if (acc_field == `ILD_FIELD_LOW)
		next_rd_data = {10'h000, low_limit[acc_port]};
	else if (acc_field == `ILD_FIELD_HIGH)
		next_rd_data = {10'h000, high_limit[acc_port]};
	else if (acc_field == `ILD_FIELD_HOLD)
		next_rd_data = hold_count[acc_port];
	else
		next_rd_data = {15'h0000, detect_config[acc_port]};
end

// unmapped or deselected reads still answer, with zero data
always @(posedge i_core_clk)
begin
	if (!i_rst_n)
	begin
		rd_data <= {`ILD_DATA_W{1'b0}};
		rd_valid <= 1'b0;
	end
	else if (i_ce)
	begin
		rd_valid <= i_rd_strobe;
		if (i_rd_strobe)
			rd_data <= next_rd_data;
	end
end

assign o_rd_data = rd_data;
assign o_rd_valid = rd_valid;

// ----------------------------------------------------------------
// per-port detector
// ----------------------------------------------------------------
wire [1:0] ind_first;
wire [1:0] ind_second;

genvar p;
generate
	for (p = 0; p < 2; p = p + 1)
	begin : g_port
		reg [2:0] state;
		reg [`ILD_HOLD_W-1:0] dwell;
		reg out_first;
		reg out_second;
		wire [`ILD_LIMIT_W-1:0] mant;
		wire low_met;
		wire high_met;
		wire enabled;
		wire active;
		wire delayed;
		wire pol;
		wire ilv;
		wire lvl_on;

		assign mant = sample_s[p][`ILD_MANT_MSB:`ILD_MANT_LSB];
		assign low_met = (mant <= low_limit[p]);
		assign high_met = (mant >= high_limit[p]);
		assign enabled = (hold_count[p] != `ILD_RST_HOLD);

		// upper wins when both limits are met at once
		always @(posedge i_core_clk)
		begin
			if (!i_rst_n)
			begin
				state <= ST_IDLE;
				dwell <= `ILD_RST_HOLD;
			end
			else if (i_ce)
			begin
				if (!enabled)
				begin
					state <= ST_IDLE;
					dwell <= `ILD_RST_HOLD;
				end
				else
				begin
					case (state)
						ST_IDLE:
						begin
							if (high_met)
							begin
								state <= ST_ARMED;
								dwell <= hold_count[p];
							end
						end
						ST_ARMED:
						begin
							if (high_met)
								dwell <= hold_count[p];
							else if (low_met)
							begin
								// the first cycle at the lower limit counts
								if (hold_count[p] == 20'h00001)
									state <= ST_IDLE;
								else
								begin
									state <= ST_DWELL;
									dwell <= hold_count[p] - 20'h00001;
								end
							end
						end
						ST_DWELL:
						begin
							if (high_met)
							begin
								state <= ST_ARMED;
								dwell <= hold_count[p];
							end
							else if (!low_met)
							begin
								state <= ST_ARMED;
								dwell <= hold_count[p];
							end
							else if (dwell == 20'h00001)
								state <= ST_IDLE;
							else
								dwell <= dwell - 20'h00001;
						end
						default:
						begin
							state <= ST_IDLE;
							dwell <= `ILD_RST_HOLD;
						end
					endcase
				end
			end
		end

		assign active = (state != ST_IDLE);

		ild_holdoff u_holdoff (
			.i_core_clk(i_core_clk),
			.i_rst_n(i_rst_n),
			.i_ce(i_ce),
			.i_level(active),
			.i_sel(detect_config[p][`ILD_CFG_HOLDOFF_MSB:`ILD_CFG_HOLDOFF_LSB]),
			.o_level(delayed)
		);

		assign pol = detect_config[p][`ILD_CFG_POLARITY_BIT];
		assign ilv = detect_config[p][`ILD_CFG_INTERLEAVE_BIT];
		assign lvl_on = delayed ^ pol;

		always @(posedge i_core_clk)
		begin
			if (!i_rst_n)
			begin
				out_first <= 1'b0;
				out_second <= 1'b0;
			end
			else if (i_ce)
			begin
				if (ilv)
				begin
					// the idle output sits at its inactive level
					out_first <= (delayed & ~ien_s[p]) ^ pol;
					out_second <= (delayed & ien_s[p]) ^ pol;
				end
				else
				begin
					out_first <= lvl_on;
					out_second <= ~lvl_on;
				end
			end
		end

		assign ind_first[p] = out_first;
		assign ind_second[p] = out_second;
	end
endgenerate

// ----------------------------------------------------------------
// outputs
// ----------------------------------------------------------------
assign o_port_a_indicator_first = ind_first[0];
assign o_port_a_indicator_second = ind_second[0];
assign o_port_b_indicator_first = ind_first[1];
assign o_port_b_indicator_second = ind_second[1];

endmodule
`default_nettype wire

// file: ild_frontend_model.sv
// ild_frontend_model.sv: converter front end that feeds both sample pins.
// assumes: the bench picks the top ten mantissa bits on the sample clock.
`timescale 1ns/1ps
`default_nettype none

module ild_frontend_model (
	// clock
	input wire i_core_clk,
	// requested mantissa
	input wire [9:0] i_mant_a,
	input wire [9:0] i_mant_b,
	// sample pins
	output logic [13:0] o_bus_a,
	output logic [13:0] o_bus_b
);
	// low bits never rest, so a detector that looks below the mantissa is caught
	logic [3:0] noise = 4'h0;
	always @(posedge i_core_clk)
		noise <= noise + 4'h7;
	assign o_bus_a = {i_mant_a, noise};
	assign o_bus_b = {i_mant_b, ~noise};
endmodule

`default_nettype wire

// file: ild_top_assertions.sv
// ild_top_assertions.sv: port checker for the level detector.
// assumes: bound to ild_top; one clock, synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module ild_chk (
	// clock and reset
	input wire i_core_clk,
	input wire i_rst_n,
	input wire i_ce,
	// access and port a pins
	input wire i_map_select,
	input wire [7:0] i_channel_address_pointer,
	input wire i_wr_strobe,
	input wire i_rd_strobe,
	input wire [19:0] i_wr_data,
	input wire [19:0] o_rd_data,
	input wire o_rd_valid,
	input wire o_port_a_indicator_first,
	input wire o_port_a_indicator_second
);
	// ----------------------------------------
	// shadow of port a settings
	// ----------------------------------------
	logic [4:0] cfg_a;
	logic hz_a;
	logic [3:0] quiet;
	logic wr_a;
	assign wr_a = i_ce && i_wr_strobe && i_map_select && i_channel_address_pointer < 8'h04;
	always @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			cfg_a <= 5'h00;
			hz_a <= 1'b1;
			quiet <= 4'h0;
		end
		else if (wr_a)
		begin
			quiet <= 4'h0;
			if (i_channel_address_pointer == 8'h03)
				cfg_a <= i_wr_data[4:0];
			if (i_channel_address_pointer == 8'h02)
				hz_a <= i_wr_data == 20'h00000;
		end
		// wide margin covers hold-off plus pipeline after any change
		else if (quiet != 4'hF && i_ce)
			quiet <= quiet + 4'h1;
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_rd;
		i_ce && i_rd_strobe;
	endsequence
	sequence s_unmapped;
		i_ce && i_rd_strobe && (!i_map_select || i_channel_address_pointer > 8'h07);
	endsequence

	a_read_answer: assert property (s_rd |=> o_rd_valid)
		else $error("read got no answer");
	a_valid_cause: assert property (o_rd_valid |-> $past(i_ce && i_rd_strobe))
		else $error("answer without a read");
	a_valid_pulse: assert property (s_rd ##1 (i_ce && !i_rd_strobe) |=> !o_rd_valid)
		else $error("answer longer than one cycle");
	a_unmapped_zero: assert property (s_unmapped |=> o_rd_data == 20'h00000)
		else $error("unmapped read not zero");
	a_data_holds: assert property (!o_rd_valid |-> $stable(o_rd_data))
		else $error("read data moved without a read");
	a_reset_clear: assert property (@(posedge i_core_clk) disable iff (1'b0)
		!i_rst_n |=> !o_rd_valid && o_rd_data == 20'h00000
		&& !o_port_a_indicator_first && !o_port_a_indicator_second)
		else $error("outputs not cleared by reset");
	a_single_compl: assert property (quiet == 4'hF && !cfg_a[3]
		|-> o_port_a_indicator_first != o_port_a_indicator_second)
		else $error("single mode outputs not complementary");
	a_disabled_idle: assert property (quiet == 4'hF && hz_a
		|-> o_port_a_indicator_first == cfg_a[4]
		&& o_port_a_indicator_second == (cfg_a[4] ^ !cfg_a[3]))
		else $error("disabled detector not inactive");
endmodule

`default_nettype wire

// file: ild_top_bench.sv
// ild_top_bench.sv: self-checking bench for ild_top.
// assumes: ild_top, ild_chk and ild_frontend_model compiled first.
`timescale 1ns/1ps
`default_nettype none

module ild_top_bench;
	logic i_core_clk = 1'b0;
	logic i_rst_n, i_ce, i_map_select, i_wr_strobe, i_rd_strobe;
	logic i_port_a_input_enable, i_port_b_input_enable;
	logic [7:0] i_channel_address_pointer;
	logic [19:0] i_wr_data, o_rd_data;
	logic [13:0] i_port_a_sample_bus, i_port_b_sample_bus;
	logic o_rd_valid, o_port_a_indicator_first, o_port_a_indicator_second;
	logic o_port_b_indicator_first, o_port_b_indicator_second;
	logic [9:0] ma, mb;
	logic [3:0] ind;
	logic [19:0] setup [4] = '{20'h0000A, 20'h00064, 20'h00003, 20'h00000};
	int mismatches = 0;
	int n_compared = 0;
	int cyc = 0;

	always #12.5 i_core_clk = ~i_core_clk;
	assign ind = {o_port_a_indicator_first, o_port_a_indicator_second,
		o_port_b_indicator_first, o_port_b_indicator_second};
	ild_top ild_top_i (.*);
	ild_frontend_model ild_frontend_model_i (
		.i_core_clk(i_core_clk),
		.i_mant_a(ma),
		.i_mant_b(mb),
		.o_bus_a(i_port_a_sample_bus),
		.o_bus_b(i_port_b_sample_bus)
	);

	// ----------------------------------------
	// access and check tasks
	// ----------------------------------------
	task automatic chk(input string n, input logic [20:0] e, input logic [20:0] g);
		n_compared++;
		if (g !== e)
		begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] p, input logic [19:0] d, input logic m);
		@(posedge i_core_clk);
		i_channel_address_pointer <= p;
		i_wr_data <= d;
		i_map_select <= m;
		i_wr_strobe <= 1'b1;
		@(posedge i_core_clk);
		i_wr_strobe <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] p, input logic [19:0] e);
		@(posedge i_core_clk);
		i_channel_address_pointer <= p;
		i_map_select <= 1'b1;
		i_rd_strobe <= 1'b1;
		@(posedge i_core_clk);
		i_rd_strobe <= 1'b0;
		#1 chk("rd", {1'b1, e}, {o_rd_valid, o_rd_data});
	endtask
	task automatic wt(input int n, input logic [3:0] e);
		repeat (n) @(posedge i_core_clk);
		#1 chk("ind", {17'h00000, e}, {17'h00000, ind});
	endtask
	// m stands for n+1 sample periods, until the edge at which the next step starts
	task automatic step(input logic [9:0] m, input int n, input logic [3:0] e);
		@(posedge i_core_clk);
		ma <= m;
		wt(n, e);
	endtask
	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	always @(posedge i_core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			mismatches++;
			stop_test();
		end
	end

	initial
	begin
		i_rst_n <= 1'b0;
		i_ce <= 1'b1;
		i_map_select <= 1'b1;
		i_wr_strobe <= 1'b0;
		i_rd_strobe <= 1'b0;
		i_channel_address_pointer <= 8'h00;
		i_wr_data <= 20'h00000;
		i_port_a_input_enable <= 1'b0;
		i_port_b_input_enable <= 1'b0;
		ma <= 10'h000;
		mb <= 10'h000;
		repeat (6) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		wt(1, 4'h5);
		for (int p = 0; p < 8; p++)
			rd(p[7:0], 20'h00000);
		for (int p = 0; p < 8; p++)
		begin
			wr(p[7:0], 20'hFFFFF, 1'b1);
			rd(p[7:0], p[1:0] == 2'h2 ? 20'hFFFFF : p[1:0] == 2'h3 ? 20'h0001F : 20'h003FF);
		end
		rd(8'h08, 20'h00000);
		wr(8'h00, 20'h00005, 1'b0);
		rd(8'h00, 20'h003FF);
		for (int p = 0; p < 8; p++)
			wr(p[7:0], setup[p[1:0]], 1'b1);
		step(10'h063, 8, 4'h5);
		step(10'h064, 3, 4'h5);
		wt(1, 4'h9);
		step(10'h00A, 5, 4'h9);
		wt(1, 4'h5);
		step(10'h0C8, 5, 4'h9);
		step(10'h005, 1, 4'h9);
		step(10'h00B, 3, 4'h9);
		step(10'h005, 5, 4'h9);
		wt(1, 4'h5);
		wr(8'h03, 20'h00013, 1'b1);
		wt(6, 4'h9);
		step(10'h0C8, 6, 4'h9);
		wt(1, 4'h5);
		step(10'h005, 8, 4'h5);
		wt(1, 4'h9);
		wr(8'h03, 20'h00008, 1'b1);
		@(posedge i_core_clk);
		i_port_a_input_enable <= 1'b1;
		wt(6, 4'h1);
		step(10'h0C8, 3, 4'h1);
		wt(1, 4'h5);
		@(posedge i_core_clk);
		i_port_a_input_enable <= 1'b0;
		wt(5, 4'h9);
		step(10'h005, 5, 4'h9);
		wt(1, 4'h1);
		wr(8'h03, 20'h00000, 1'b1);
		wr(8'h02, 20'h00000, 1'b1);
		step(10'h0C8, 12, 4'h5);
		step(10'h000, 2, 4'h5);
		@(posedge i_core_clk);
		mb <= 10'h0C8;
		wt(5, 4'h6);
		// clock enable low must freeze the indicator even as the input falls
		@(posedge i_core_clk);
		i_ce <= 1'b0;
		mb <= 10'h000;
		wt(8, 4'h6);
		@(posedge i_core_clk);
		i_ce <= 1'b1;
		wt(8, 4'h5);
		// port B interleaved: a high input enable must steer detection to its second output
		wr(8'h07, 20'h00008, 1'b1);
		wt(1, 4'h4);
		@(posedge i_core_clk);
		i_port_b_input_enable <= 1'b1;
		mb <= 10'h0C8;
		wt(8, 4'h5);
		stop_test();
	end
endmodule

bind ild_top ild_chk ild_chk_i (.*);

`default_nettype wire
